// ### core/cms_pkg.sv
// Constants and types shared by the clock mode select block
package cms_pkg;

	// Mode field codes
	localparam logic [2:0] MODE_NORMAL_CODE = 3'h5;
	localparam logic [2:0] MODE_DIV2_CODE   = 3'h0;
	localparam logic [2:0] MODE_CHIP_CODE   = 3'h1;
	localparam logic [2:0] MODE_MODULE_CODE = 3'h2;
	localparam logic [2:0] MODE_CLKRST_CODE = 3'h3;

	// Divider selection, as log2 of the ratio
	localparam logic [1:0] DIV_LOG2_ONE  = 2'h0;
	localparam logic [1:0] DIV_LOG2_TWO  = 2'h1;
	localparam logic [1:0] DIV_LOG2_FOUR = 2'h2;

	// System clock output: internal ticks per half period
	localparam logic [1:0] SYS_HALF_TICKS = 2'h2;

	// Reference alignment window: offsets in ns and oscillator cycles, oscillator period in ps
	localparam int REF_OFFSET_MIN_NS  = 0;
	localparam int OSC_PERIOD_PS      = 8000;
	localparam int REF_OFFSET_MAX_CYC = 1;

	// Reset values
	localparam logic [2:0] MODE_RESET_CODE = 3'h3;

	typedef enum logic [2:0] {
		CMS_NORMAL,
		CMS_DIV2,
		CMS_CHIP_TEST,
		CMS_MODULE_TEST,
		CMS_CLOCK_RESET,
		CMS_INVALID
	} cms_mode_t;

	function automatic cms_mode_t cms_decode(input logic [2:0] code);
		case (code)
			MODE_NORMAL_CODE: cms_decode = CMS_NORMAL;
			MODE_DIV2_CODE:   cms_decode = CMS_DIV2;
			MODE_CHIP_CODE:   cms_decode = CMS_CHIP_TEST;
			MODE_MODULE_CODE: cms_decode = CMS_MODULE_TEST;
			MODE_CLKRST_CODE: cms_decode = CMS_CLOCK_RESET;
			default:          cms_decode = CMS_INVALID;
		endcase
	endfunction : cms_decode

	function automatic logic [1:0] cms_last_count(input logic [1:0] div_log2);
		cms_last_count = 2'((3'h1 << div_log2) - 3'h1);
	endfunction : cms_last_count

endpackage : cms_pkg

// ### core/cms_div_if.sv
// Control and tick signals between the mode decoder and the divider
`timescale 1ns/1ps
`default_nettype none
interface cms_div_if;
	logic [1:0] div_log2;
	logic       hold;
	logic       tick;

	modport ctrl (output div_log2, output hold, input tick);
	modport div  (input div_log2, input hold, output tick);
endinterface : cms_div_if
`default_nettype wire

// ### core/cms_div.sv
// Oscillator divider producing the internal clock tick
`timescale 1ns/1ps
`default_nettype none
module cms_div (
	input  wire logic clock,
	input  wire logic rst_n,
	input  wire logic clk_en,
	cms_div_if.div    dif
);

	typedef struct packed {
		logic [1:0] cnt;
		logic       tick;
	} cms_div_st_t;

	cms_div_st_t st_ff;
	cms_div_st_t nxt_st;

	assign dif.tick = st_ff.tick;

	always_comb begin
		nxt_st = st_ff;
		if (dif.hold) begin
			nxt_st.cnt  = 2'h0;
			nxt_st.tick = 1'b0;
		end else begin
			// Tick once every 1, 2 or 4 oscillator cycles
			nxt_st.tick = (st_ff.cnt == cms_pkg::cms_last_count(dif.div_log2));
			nxt_st.cnt  = nxt_st.tick ? 2'h0 : 2'(st_ff.cnt + 2'h1);
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st_ff <= '0;
		end else if (clk_en) begin
			st_ff <= nxt_st;
		end
	end

	chk_half_gap: assert property (@(posedge clock) disable iff (!rst_n)
		(st_ff.tick && clk_en && dif.div_log2 == cms_pkg::DIV_LOG2_TWO) |=> !st_ff.tick)
		else $error("Divide by two ticked on consecutive cycles");

	chk_half_period: assert property (@(posedge clock) disable iff (!rst_n)
		(st_ff.tick && clk_en && dif.div_log2 == cms_pkg::DIV_LOG2_TWO)
		##1 (clk_en && !dif.hold && dif.div_log2 == cms_pkg::DIV_LOG2_TWO) |=> st_ff.tick)
		else $error("Divide by two missed its second cycle tick");

	chk_bypass_tick: assert property (@(posedge clock) disable iff (!rst_n)
		(clk_en && !dif.hold && dif.div_log2 == cms_pkg::DIV_LOG2_ONE && st_ff.cnt == 2'h0)
		|=> st_ff.tick)
		else $error("Undivided path failed to tick every cycle");

	chk_quarter_gap: assert property (@(posedge clock) disable iff (!rst_n)
		(st_ff.tick && clk_en && dif.div_log2 == cms_pkg::DIV_LOG2_FOUR) |=> !st_ff.tick)
		else $error("Divide by four ticked too early");

	chk_quarter_period: assert property (@(posedge clock) disable iff (!rst_n)
		(st_ff.tick && clk_en && dif.div_log2 == cms_pkg::DIV_LOG2_FOUR)
		##1 (clk_en && !dif.hold && dif.div_log2 == cms_pkg::DIV_LOG2_FOUR)[*3] |=> st_ff.tick)
		else $error("Divide by four missed its fourth cycle tick");

endmodule : cms_div
`default_nettype wire

// ### core/cms_top.sv
// Clock mode decoder and system clock output generator
`timescale 1ns/1ps
`default_nettype none

module cms_top (
	input  wire logic       clock,
	input  wire logic       rst_n,
	input  wire logic       clk_en,
	input  wire logic [2:0] clock_mode,
	input  wire logic       ref_clock_in,
	output logic            int_clk_tick,
	output logic            equalizer_en,
	output logic            divider_bypass,
	output logic            sys_gen_in_reset,
	output logic            system_clock_output,
	output logic            ref_aligned,
	output logic            mode_invalid
);

	typedef struct packed {
		logic [2:0] mode_s1;
		logic [2:0] mode_s2;
		logic       ref_s1;
		logic       ref_s2;
		logic       ref_d;
		logic [1:0] sys_cnt;
		logic       tick;
		logic       equalizer_en;
		logic       divider_bypass;
		logic       sys_gen_in_reset;
		logic       system_clock_output;
		logic       ref_aligned;
		logic       mode_invalid;
	} cms_top_st_t;

	cms_top_st_t      st_ff;
	cms_top_st_t      nxt_st;
	cms_pkg::cms_mode_t mode;
	logic             ref_rise;

	cms_div_if dif ();

	cms_div u_div (
		.clock  (clock),
		.rst_n  (rst_n),
		.clk_en (clk_en),
		.dif    (dif)
	);

	assign mode     = cms_pkg::cms_decode(st_ff.mode_s2);
	assign ref_rise = st_ff.ref_s2 && !st_ff.ref_d;

	// Divider selection from the decoded mode
	always_comb begin
		dif.hold     = 1'b0;
		dif.div_log2 = cms_pkg::DIV_LOG2_ONE;
		case (mode)
			cms_pkg::CMS_NORMAL:      dif.div_log2 = cms_pkg::DIV_LOG2_ONE;
			cms_pkg::CMS_DIV2:        dif.div_log2 = cms_pkg::DIV_LOG2_TWO;
			cms_pkg::CMS_CHIP_TEST:   dif.div_log2 = cms_pkg::DIV_LOG2_ONE;
			cms_pkg::CMS_MODULE_TEST: dif.div_log2 = cms_pkg::DIV_LOG2_FOUR;
			cms_pkg::CMS_CLOCK_RESET: dif.hold = 1'b1;
			default:                  dif.hold = 1'b1;
		endcase
	end

	always_comb begin
		nxt_st = st_ff;
		// Pin synchronisers
		nxt_st.mode_s1 = clock_mode;
		nxt_st.mode_s2 = st_ff.mode_s1;
		nxt_st.ref_s1  = ref_clock_in;
		nxt_st.ref_s2  = st_ff.ref_s1;
		nxt_st.ref_d   = st_ff.ref_s2;
		nxt_st.tick    = dif.tick;

		nxt_st.equalizer_en     = (mode == cms_pkg::CMS_NORMAL);
		nxt_st.divider_bypass   = (mode == cms_pkg::CMS_CHIP_TEST);
		nxt_st.mode_invalid     = (mode == cms_pkg::CMS_INVALID);
		nxt_st.sys_gen_in_reset = (mode == cms_pkg::CMS_CLOCK_RESET) ||
			(mode == cms_pkg::CMS_INVALID);

		if (nxt_st.sys_gen_in_reset) begin
			// Known state for tester synchronisation
			nxt_st.sys_cnt             = 2'h0;
			nxt_st.system_clock_output = 1'b0;
			nxt_st.ref_aligned         = 1'b0;
		end else if (mode == cms_pkg::CMS_MODULE_TEST && ref_rise) begin
			// Restart the output phase on the reference edge
			nxt_st.sys_cnt             = 2'h0;
			nxt_st.system_clock_output = 1'b1;
			nxt_st.ref_aligned         = 1'b1;
		end else begin
			if (mode != cms_pkg::CMS_MODULE_TEST) begin
				nxt_st.ref_aligned = 1'b0;
			end
			if (dif.tick) begin
				if (st_ff.sys_cnt == 2'(cms_pkg::SYS_HALF_TICKS - 2'h1)) begin
					nxt_st.sys_cnt             = 2'h0;
					nxt_st.system_clock_output = !st_ff.system_clock_output;
				end else begin
					nxt_st.sys_cnt = 2'(st_ff.sys_cnt + 2'h1);
				end
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st_ff                  <= '0;
			st_ff.mode_s1          <= cms_pkg::MODE_RESET_CODE;
			st_ff.mode_s2          <= cms_pkg::MODE_RESET_CODE;
			st_ff.sys_gen_in_reset <= 1'b1;
		end else if (clk_en) begin
			st_ff <= nxt_st;
		end
	end

	assign int_clk_tick        = st_ff.tick;
	assign equalizer_en        = st_ff.equalizer_en;
	assign divider_bypass      = st_ff.divider_bypass;
	assign sys_gen_in_reset    = st_ff.sys_gen_in_reset;
	assign system_clock_output = st_ff.system_clock_output;
	assign ref_aligned         = st_ff.ref_aligned;
	assign mode_invalid        = st_ff.mode_invalid;

	chk_normal_equal: assert property (@(posedge clock) disable iff (!rst_n)
		(clk_en && st_ff.mode_s2 == cms_pkg::MODE_NORMAL_CODE)
		|=> equalizer_en && !divider_bypass && !sys_gen_in_reset)
		else $error("Normal mode did not enable the equalizer");

	chk_bypass_flag: assert property (@(posedge clock) disable iff (!rst_n)
		(clk_en && st_ff.mode_s2 == cms_pkg::MODE_CHIP_CODE) |=> divider_bypass)
		else $error("Chip test mode did not flag divider bypass");

	chk_bypass_noequal: assert property (@(posedge clock) disable iff (!rst_n)
		divider_bypass |-> !equalizer_en)
		else $error("Equalizer on during divider bypass");

	chk_ref_align: assert property (@(posedge clock) disable iff (!rst_n)
		(clk_en && ref_rise && st_ff.mode_s2 == cms_pkg::MODE_MODULE_CODE)
		|=> system_clock_output && ref_aligned)
		else $error("System clock output not aligned to reference edge");

	chk_gen_reset: assert property (@(posedge clock) disable iff (!rst_n)
		(clk_en && st_ff.mode_s2 == cms_pkg::MODE_CLKRST_CODE)
		|=> sys_gen_in_reset && !system_clock_output ##1 (!clk_en || !system_clock_output))
		else $error("Clock reset mode did not hold the generator");

	chk_invalid_held: assert property (@(posedge clock) disable iff (!rst_n)
		(clk_en && mode == cms_pkg::CMS_INVALID)
		|=> mode_invalid && sys_gen_in_reset && !system_clock_output)
		else $error("Invalid mode code did not hold the generator");

	chk_valid_clear: assert property (@(posedge clock) disable iff (!rst_n)
		(clk_en && mode != cms_pkg::CMS_INVALID) |=> !mode_invalid)
		else $error("Invalid flag raised for a valid mode code");

	chk_aligned_clear: assert property (@(posedge clock) disable iff (!rst_n)
		(clk_en && mode != cms_pkg::CMS_MODULE_TEST) |=> !ref_aligned)
		else $error("Reference alignment flag set outside module test");

	chk_equal_only: assert property (@(posedge clock) disable iff (!rst_n)
		(clk_en && mode != cms_pkg::CMS_NORMAL) |=> !equalizer_en)
		else $error("Equalizer enabled outside normal mode");

	chk_tick_follow: assert property (@(posedge clock) disable iff (!rst_n)
		clk_en |=> (int_clk_tick == $past(dif.tick)))
		else $error("Internal tick output does not follow the divider");

	chk_hold_notick: assert property (@(posedge clock) disable iff (!rst_n)
		(clk_en && dif.hold) |=> !dif.tick)
		else $error("Divider ticked while held");

endmodule : cms_top
`default_nettype wire

// ### sim/cms_board_model.sv
// Board strapping and reference clock source for the clock mode block
`timescale 1ns/1ps
`default_nettype none
module cms_board_model (
	input  wire logic       clock,
	input  wire logic       rst_n,
	input  wire logic [2:0] req_mode,
	input  wire logic       ref_pulse,
	output logic      [2:0] clock_mode,
	output logic            ref_clock_in
);
	initial begin
		clock_mode = 3'h5;
		ref_clock_in = 1'b0;
	end
	// Straps move only while the device is held in reset
	always @(posedge clock) begin
		if (!rst_n) clock_mode <= req_mode;
		ref_clock_in <= ref_pulse;
	end
endmodule : cms_board_model
`default_nettype wire

// ### sim/tb_top.sv
// Self-checking bench for the clock mode select block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic       clock, rst_n, clk_en, ref_pulse, ref_clock_in, last_out;
	logic [2:0] req_mode, clock_mode;
	logic       int_clk_tick, equalizer_en, divider_bypass, sys_gen_in_reset;
	logic       system_clock_output, ref_aligned, mode_invalid;
	int         fail_count, samples_checked, cycles, ticks, toggles, ratio;

	initial clock = 1'b0;
	always #4 clock = ~clock;

	cms_board_model board (.clock(clock), .rst_n(rst_n), .req_mode(req_mode),
		.ref_pulse(ref_pulse), .clock_mode(clock_mode), .ref_clock_in(ref_clock_in));
	cms_top dut (.clock(clock), .rst_n(rst_n), .clk_en(clk_en), .clock_mode(clock_mode),
		.ref_clock_in(ref_clock_in), .int_clk_tick(int_clk_tick),
		.equalizer_en(equalizer_en), .divider_bypass(divider_bypass),
		.sys_gen_in_reset(sys_gen_in_reset), .system_clock_output(system_clock_output),
		.ref_aligned(ref_aligned), .mode_invalid(mode_invalid));

	task automatic stop_test;
		if (fail_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : stop_test

	task automatic chk(input string name, input int exp, input logic [7:0] got);
		samples_checked++;
		if (got !== 8'(exp)) begin
			$display("ERROR %s expected %0d seen %0d", name, exp, got);
			fail_count++;
		end
	endtask : chk

	// Cuts a hang short
	always @(posedge clock) begin
		cycles++;
		if (cycles == 2000) begin
			fail_count++;
			stop_test();
		end
	end

	initial begin
		rst_n = 1'b0;
		clk_en = 1'b1;
		req_mode = 3'h5;
		ref_pulse = 1'b0;
		fail_count = 0;
		samples_checked = 0;
		cycles = 0;
		void'($urandom(63));
		repeat (5) @(negedge clock);
		for (int code = 0; code < 8; code++) begin
			rst_n = 1'b0;
			req_mode = 3'(code);
			repeat (5) @(negedge clock);
			chk("gen_held_in_reset", 1, {7'h0, sys_gen_in_reset});
			rst_n = 1'b1;
			repeat (8) @(negedge clock);
			ratio = (code == 5 || code == 1) ? 1 : (code == 0) ? 2 : (code == 2) ? 4 : 0;
			chk("equalizer_en", int'(code == 5), {7'h0, equalizer_en});
			chk("divider_bypass", int'(code == 1), {7'h0, divider_bypass});
			chk("sys_gen_in_reset", int'(ratio == 0), {7'h0, sys_gen_in_reset});
			chk("mode_invalid", int'(code == 4 || code > 5), {7'h0, mode_invalid});
			chk("ref_aligned_idle", 0, {7'h0, ref_aligned});
			ticks = 0;
			toggles = 0;
			last_out = system_clock_output;
			repeat (64) begin
				@(negedge clock);
				ticks += int'(int_clk_tick === 1'b1);
				toggles += int'(system_clock_output !== last_out);
				last_out = system_clock_output;
			end
			chk("tick_count", ratio == 0 ? 0 : 64 / ratio, 8'(ticks));
			chk("sysclk_toggles", ratio == 0 ? 0 : 32 / ratio, 8'(toggles));
			repeat ($urandom_range(3)) @(negedge clock);
			ref_pulse = 1'b1;
			repeat (2) @(negedge clock);
			ref_pulse = 1'b0;
			repeat (4) @(negedge clock);
			chk("ref_aligned", int'(code == 2), {7'h0, ref_aligned});
			if (code == 2) chk("sysclk_after_ref", 1, {7'h0, system_clock_output});
		end
		stop_test();
	end
endmodule : tb_top
`default_nettype wire
